/* core/servo_torque_pkg.sv */
// constants, register map and defaults of the torque mode command path
// assumes a 32-bit apb master and a 40 mhz ref_clk
// Summary of operation
// - two select inputs pick analog torque (00) or stored commands a, b, c
// - basic variant uses analog torque only; stored commands need enhanced
// - at 100% scale, 10 V gives 100% rated torque, 5 V gives 50%
// - torque equals command voltage times scale; scale 0..2000%, resets 100
// - signed millivolt offset trim added to analog torque, -8000..8000, 0
// - torque command filter constant 0..5000 ms, default 0, torque mode only
// - two torque limits 0..100%, both default 100, clamp generated torque
// - limit select off uses first limit; on uses smaller of both
// - limit select input acts only once its input assignment is enabled
// - digital input reads 1 when shorted to common, 0 when open
// - third speed input disabled: 00 analog limit, 01..11 stored one..three
// - third speed input enabled: 000 analog, 001..111 stored one..seven
// - third speed input works only after it is assigned
// - stored speed limits reset 100,500,1000,200,300,500,800; capped
// - interpolation mode one: only position gain adjustable, rest estimated
// - interpolation mode two, enhanced only: inertia and position adjustable
// - analog speed limit scaled by full-scale speed 0..30000, default 3000
package servo_torque_pkg;
    // timing
    localparam int CLK_HZ = 40000000;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TQ_SCALE = 8'h08;
    localparam logic [7:0] ADDR_TQ_OFFSET = 8'h0c;
    localparam logic [7:0] ADDR_TQ_FILTER = 8'h10;
    localparam logic [7:0] ADDR_TQ_LIM1 = 8'h14;
    localparam logic [7:0] ADDR_TQ_LIM2 = 8'h18;
    localparam logic [7:0] ADDR_TQ_STORED0 = 8'h1c;
    localparam logic [7:0] ADDR_MAX_SPEED = 8'h28;
    localparam logic [7:0] ADDR_SPD_STORED0 = 8'h2c;
    localparam logic [7:0] ADDR_INERTIA = 8'h48;
    localparam logic [7:0] ADDR_POS_GAIN = 8'h4c;
    localparam logic [7:0] ADDR_SPD_GAIN = 8'h50;
    localparam logic [7:0] ADDR_SPD_INTEG = 8'h54;
    localparam logic [7:0] ADDR_TQ_OUT = 8'h58;
    localparam logic [7:0] ADDR_SPD_OUT = 8'h5c;
    // control field positions
    localparam int CTRL_TQ_MODE = 0;
    localparam int CTRL_ASSIGN_TL = 1;
    localparam int CTRL_ASSIGN_SP3 = 2;
    localparam int CTRL_INTERP_LO = 4;
    // interpolation modes
    localparam logic [1:0] INTERP_OFF = 2'h0;
    localparam logic [1:0] INTERP_ONE = 2'h1;
    localparam logic [1:0] INTERP_TWO = 2'h2;
    // ranges and reset values
    localparam int SCALE_MAX = 2000;
    localparam int SCALE_DEF = 100;
    localparam int OFFSET_MAX = 8000;
    localparam int FILTER_MAX = 5000;
    localparam int LIMIT_MAX = 100;
    localparam int STORED_TQ_MAX = 300;
    localparam int MAX_SPEED_MAX = 30000;
    localparam int MAX_SPEED_DEF = 3000;
    localparam int FULL_SCALE_MV = 10000;
    localparam int PCT_TENTHS = 10;
    localparam int INERTIA_MAX = 1200;
    localparam int INERTIA_DEF = 70;
    localparam int POS_GAIN_MIN = 4;
    localparam int POS_GAIN_MAX = 1024;
    localparam int POS_GAIN_DEF = 45;
    localparam int SPD_GAIN_MIN = 40;
    localparam int SPD_GAIN_MAX = 9000;
    localparam int SPD_GAIN_DEF = 183;
    localparam int SPD_INTEG_MIN = 1;
    localparam int SPD_INTEG_MAX = 1000;
    localparam int SPD_INTEG_DEF = 34;
    localparam int SPD_STORED_N = 7;
    localparam logic [15:0] SPD_STORED_DEF [SPD_STORED_N] = '{
        16'h0064, 16'h01f4, 16'h03e8, 16'h00c8, 16'h012c, 16'h01f4, 16'h0320};
    localparam int FILT_FRAC = 16;
endpackage

/* core/servo_torque_mode_command_path.sv */
// torque mode command path: source select, offset, scale, filter, clamp,
// speed limit select and gain ownership under interpolation modes
// assumes digital pins are synchronous to ref_clk, low when shorted to common
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module servo_torque_mode_command_path
    import servo_torque_pkg::*;
#(
    parameter int ENHANCED = 1,
    parameter int MS_CYCLES = MS_CYCLES_DEF,
    parameter int PERMISSIBLE_RPM = 6000
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic torqueSourceSelLowN,
    input wire logic torqueSourceSelHighN,
    input wire logic torqueLimitSelectN,
    input wire logic speedSelectBit0N,
    input wire logic speedSelectBit1N,
    input wire logic speedSelectBit2N,
    input wire logic signed [15:0] torqueAnalogMv,
    input wire logic signed [15:0] speedAnalogMv,
    input wire logic [15:0] estInertiaRatio,
    input wire logic [15:0] estSpeedGain,
    input wire logic [15:0] estSpeedIntegral,
    output logic signed [15:0] torqueCmd,
    output logic signed [15:0] speedLimit,
    output logic [15:0] loadInertiaRatio,
    output logic [15:0] positionLoopGain,
    output logic [15:0] speedLoopGain,
    output logic [15:0] speedIntegralGain,
    output logic autoInertia,
    output logic autoSpeedGains
);

    initial begin
        if (ENHANCED != 0 && ENHANCED != 1)
            $error("ENHANCED must be 0 or 1");
        if (MS_CYCLES < 2 || PERMISSIBLE_RPM < 1 || PERMISSIBLE_RPM > 32767)
            $error("MS_CYCLES or PERMISSIBLE_RPM out of range");
    end

    function automatic logic signed [31:0] sat(input logic signed [31:0] v,
            input logic signed [31:0] lo, input logic signed [31:0] hi);
        if (v < lo)
            sat = lo;
        else if (v > hi)
            sat = hi;
        else
            sat = v;
    endfunction

    // ----------------
    // apb slave
    // ----------------
    logic wrEn;
    logic rdEn;
    logic signed [31:0] wval;

    logic [7:0] ctrl_q;
    logic [15:0] tqScale_q;
    logic signed [15:0] tqOffset_q;
    logic [15:0] tqFilter_q;
    logic [15:0] tqLim1_q;
    logic [15:0] tqLim2_q;
    logic signed [15:0] tqStored_q [3];
    logic [15:0] maxSpeed_q;
    logic [15:0] spdStored_q [SPD_STORED_N];

    logic [15:0] inertiaSet_q;
    logic [15:0] posGainSet_q;
    logic [15:0] spdGainSet_q;
    logic [15:0] spdIntegSet_q;

    logic [31:0] rdata_d;
    logic mapped_d;
    logic [1:0] interpMode;
    logic [1:0] tqSrcCode;
    logic [2:0] spdCode;
    logic tlActive;

    assign wrEn = psel && penable && pready && pwrite;
    assign rdEn = psel && !penable && !pwrite;
    assign wval = $signed(pwdata);
    assign interpMode = ctrl_q[CTRL_INTERP_LO +: 2];

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            pready <= 1'b0;
        else
            pready <= psel && !penable;
    end

    always_comb begin
        rdata_d = 32'h0;
        mapped_d = 1'b1;
        case (paddr)
            ADDR_CTRL: rdata_d = {24'h0, ctrl_q};
            ADDR_STATUS: rdata_d = {22'h0, 1'(ENHANCED), autoSpeedGains,
                autoInertia, tlActive, 1'b0, spdCode, tqSrcCode};
            ADDR_TQ_SCALE: rdata_d = {16'h0, tqScale_q};
            ADDR_TQ_OFFSET: rdata_d = 32'(tqOffset_q);
            ADDR_TQ_FILTER: rdata_d = {16'h0, tqFilter_q};
            ADDR_TQ_LIM1: rdata_d = {16'h0, tqLim1_q};
            ADDR_TQ_LIM2: rdata_d = {16'h0, tqLim2_q};
            ADDR_MAX_SPEED: rdata_d = {16'h0, maxSpeed_q};
            ADDR_INERTIA: rdata_d = {16'h0, loadInertiaRatio};
            ADDR_POS_GAIN: rdata_d = {16'h0, positionLoopGain};
            ADDR_SPD_GAIN: rdata_d = {16'h0, speedLoopGain};
            ADDR_SPD_INTEG: rdata_d = {16'h0, speedIntegralGain};
            ADDR_TQ_OUT: rdata_d = 32'(torqueCmd);
            ADDR_SPD_OUT: rdata_d = 32'(speedLimit);
            default: begin
                mapped_d = 1'b0;
                for (int i = 0; i < 3; i++) begin
                    if (paddr == ADDR_TQ_STORED0 + 8'(4 * i)) begin
                        rdata_d = 32'(tqStored_q[i]);
                        mapped_d = 1'b1;
                    end
                end
                for (int i = 0; i < SPD_STORED_N; i++) begin
                    if (paddr == ADDR_SPD_STORED0 + 8'(4 * i)) begin
                        rdata_d = {16'h0, spdStored_q[i]};
                        mapped_d = 1'b1;
                    end
                end
            end
        endcase
        if (paddr[1:0] != 2'h0)
            mapped_d = 1'b0;
        if (!mapped_d)
            rdata_d = 32'h0;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && !mapped_d;
            if (psel && !penable)
                prdata <= rdEn ? rdata_d : 32'h0;
        end
    end

    // ----------------
    // settings, numeric writes saturate into their legal ranges; a refused interpolation mode loads off
    // ----------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= 8'h01;
            tqScale_q <= 16'(SCALE_DEF);
            tqOffset_q <= 16'sh0;
            tqFilter_q <= 16'h0;
            tqLim1_q <= 16'(LIMIT_MAX);
            tqLim2_q <= 16'(LIMIT_MAX);
            maxSpeed_q <= 16'(MAX_SPEED_DEF);
            inertiaSet_q <= 16'(INERTIA_DEF);
            posGainSet_q <= 16'(POS_GAIN_DEF);
            spdGainSet_q <= 16'(SPD_GAIN_DEF);
            spdIntegSet_q <= 16'(SPD_INTEG_DEF);
            for (int i = 0; i < 3; i++)
                tqStored_q[i] <= 16'sh0;
            for (int i = 0; i < SPD_STORED_N; i++)
                spdStored_q[i] <= SPD_STORED_DEF[i];
        end else if (wrEn) begin
            case (paddr)
                ADDR_CTRL: begin
                    ctrl_q <= {2'h0, pwdata[5:4], 1'b0, pwdata[2:0]};
                    // mode two is refused on the basic variant
                    if (pwdata[5:4] == 2'h3 ||
                            (ENHANCED == 0 && pwdata[5:4] == INTERP_TWO))
                        ctrl_q[CTRL_INTERP_LO +: 2] <= INTERP_OFF;
                end
                ADDR_TQ_SCALE: tqScale_q <= 16'(sat(wval, 0, SCALE_MAX));
                ADDR_TQ_OFFSET:
                    tqOffset_q <= 16'(sat(wval, -OFFSET_MAX, OFFSET_MAX));
                ADDR_TQ_FILTER: tqFilter_q <= 16'(sat(wval, 0, FILTER_MAX));
                ADDR_TQ_LIM1: tqLim1_q <= 16'(sat(wval, 0, LIMIT_MAX));
                ADDR_TQ_LIM2: tqLim2_q <= 16'(sat(wval, 0, LIMIT_MAX));
                ADDR_MAX_SPEED: maxSpeed_q <= 16'(sat(wval, 0, MAX_SPEED_MAX));
                ADDR_INERTIA:
                    inertiaSet_q <= 16'(sat(wval, 0, INERTIA_MAX));
                ADDR_POS_GAIN:
                    posGainSet_q <= 16'(sat(wval, POS_GAIN_MIN, POS_GAIN_MAX));
                ADDR_SPD_GAIN:
                    spdGainSet_q <= 16'(sat(wval, SPD_GAIN_MIN, SPD_GAIN_MAX));
                ADDR_SPD_INTEG: spdIntegSet_q <=
                    16'(sat(wval, SPD_INTEG_MIN, SPD_INTEG_MAX));
                default: begin
                    for (int i = 0; i < 3; i++)
                        if (paddr == ADDR_TQ_STORED0 + 8'(4 * i))
                            tqStored_q[i] <= 16'(sat(wval, -STORED_TQ_MAX,
                                STORED_TQ_MAX));
                    for (int i = 0; i < SPD_STORED_N; i++)
                        if (paddr == ADDR_SPD_STORED0 + 8'(4 * i))
                            spdStored_q[i] <= 16'(sat(wval, 0,
                                PERMISSIBLE_RPM));
                end
            endcase
        end
    end

    // ----------------
    // gain ownership under interpolation
    // ----------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            autoInertia <= 1'b0;
            autoSpeedGains <= 1'b0;
            loadInertiaRatio <= 16'(INERTIA_DEF);
            positionLoopGain <= 16'(POS_GAIN_DEF);
            speedLoopGain <= 16'(SPD_GAIN_DEF);
            speedIntegralGain <= 16'(SPD_INTEG_DEF);
        end else begin
            autoInertia <= interpMode == INTERP_ONE;
            autoSpeedGains <= interpMode != INTERP_OFF;
            positionLoopGain <= posGainSet_q;
            loadInertiaRatio <= (interpMode == INTERP_ONE) ?
                estInertiaRatio : inertiaSet_q;
            speedLoopGain <= (interpMode != INTERP_OFF) ?
                estSpeedGain : spdGainSet_q;
            speedIntegralGain <= (interpMode != INTERP_OFF) ?
                estSpeedIntegral : spdIntegSet_q;
        end
    end

    // ----------------
    // digital inputs and selection codes
    // ----------------
    logic diTqLo, diTqHi, diTl, diSp0, diSp1, diSp2;
    assign diTqLo = !torqueSourceSelLowN;
    assign diTqHi = !torqueSourceSelHighN;
    assign diTl = !torqueLimitSelectN;
    assign diSp0 = !speedSelectBit0N;
    assign diSp1 = !speedSelectBit1N;
    assign diSp2 = !speedSelectBit2N;

    // basic variant always takes the analog source
    assign tqSrcCode = (ENHANCED != 0) ? {diTqHi, diTqLo} : 2'h0;
    assign tlActive = diTl && ctrl_q[CTRL_ASSIGN_TL];
    assign spdCode = {diSp2 && ctrl_q[CTRL_ASSIGN_SP3],
        diSp1, diSp0};

    // ----------------
    // torque path, units of 0.1 % rated torque
    // ----------------
    logic [$clog2(MS_CYCLES)-1:0] msCnt_q;
    logic msTick;
    logic signed [17:0] tqCorrMv;
    logic signed [35:0] tqProd;
    logic signed [15:0] tqScaled_q;
    logic signed [31:0] filt_q;
    logic signed [32:0] fDiff;
    logic signed [32:0] fStep;

    logic filtBypass;
    logic signed [15:0] tqSel;
    logic signed [15:0] limSel;

    assign msTick = msCnt_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1);
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            msCnt_q <= '0;
        else
            msCnt_q <= msTick ? '0 : msCnt_q + 1'b1;
    end

    // offset is added ahead of scaling and filtering
    assign tqCorrMv = 18'(torqueAnalogMv) + 18'(tqOffset_q);
    // 10000 mV at 100 % scale gives 1000 tenths of a percent
    assign tqProd = 36'(tqCorrMv) * $signed({20'h0, tqScale_q}) * 36'sd10
        / 36'(FULL_SCALE_MV);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            tqScaled_q <= 16'sh0;
        else
            tqScaled_q <= 16'(sat(32'(tqProd), -32'sd32767, 32'sd32767));
    end

    assign filtBypass = tqFilter_q == 16'h0 || !ctrl_q[CTRL_TQ_MODE];
    assign fDiff = (33'(tqScaled_q) <<< FILT_FRAC) - 33'(filt_q);
    assign fStep = fDiff / $signed({17'h0, tqFilter_q});

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            filt_q <= 32'sh0;
        else if (filtBypass)
            filt_q <= 32'(tqScaled_q) <<< FILT_FRAC;
        else if (msTick)
            filt_q <= filt_q + 32'(fStep);
    end

    always_comb begin
        case (tqSrcCode)
            2'h0: tqSel = 16'(filt_q >>> FILT_FRAC);
            2'h1: tqSel = 16'(tqStored_q[0] * 16'sd10);
            2'h2: tqSel = 16'(tqStored_q[1] * 16'sd10);
            default: tqSel = 16'(tqStored_q[2] * 16'sd10);
        endcase
        limSel = $signed(tqLim1_q);
        if (tlActive && tqLim2_q < tqLim1_q)
            limSel = $signed(tqLim2_q);
        limSel = 16'(limSel * 16'(PCT_TENTHS));
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            torqueCmd <= 16'sh0;
        else
            torqueCmd <= 16'(sat(32'(tqSel), -32'(limSel), 32'(limSel)));
    end

    // ----------------
    // speed limit
    // ----------------
    logic signed [35:0] spdProd;
    assign spdProd = 36'(speedAnalogMv) * $signed({20'h0, maxSpeed_q})
        / 36'(FULL_SCALE_MV);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            speedLimit <= 16'sh0;
        else if (spdCode == 3'h0)
            speedLimit <= 16'(sat(32'(spdProd), -32'sd32767, 32'sd32767));
        else
            speedLimit <= $signed(spdStored_q[spdCode - 3'h1]);
    end

endmodule
`default_nettype wire

/* verification/servo_torque_props.sv */
// checker of apb timing, torque clamp and gain ownership at the top ports
// assumes the bind below and one ref_clk domain
`timescale 1ns/100ps
`default_nettype none
module servo_torque_props
    import servo_torque_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] estInertiaRatio,
    input wire logic [15:0] estSpeedGain,
    input wire logic signed [15:0] torqueCmd,
    input wire logic [15:0] loadInertiaRatio,
    input wire logic [15:0] positionLoopGain,
    input wire logic [15:0] speedLoopGain,
    input wire logic autoInertia,
    input wire logic autoSpeedGains
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    sequence s_wrote;
        $past(pwrite && pready) || $past(pwrite && pready, 2);
    endsequence
    a_ready_after_setup: assert property (s_setup |=> s_access)
        else $error("no answer after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_error_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    a_torque_clamped: assert property (
        torqueCmd <= LIMIT_MAX * PCT_TENTHS
        && torqueCmd >= -LIMIT_MAX * PCT_TENTHS)
        else $error("torque beyond full limit");
    a_inertia_needs_speed: assert property (
        autoInertia |-> autoSpeedGains)
        else $error("inertia estimated alone");
    a_speed_gain_follow: assert property (
        autoSpeedGains && $past(autoSpeedGains) && $stable(estSpeedGain)
        |-> speedLoopGain == estSpeedGain)
        else $error("speed gain not estimated");
    a_inertia_follow: assert property (
        autoInertia && $past(autoInertia) && $stable(estInertiaRatio)
        |-> loadInertiaRatio == estInertiaRatio)
        else $error("inertia not estimated");
    a_position_gain_user: assert property (
        $changed(positionLoopGain) |-> s_wrote)
        else $error("position gain changed without write");
    a_auto_from_write: assert property (
        $changed(autoSpeedGains) |-> s_wrote)
        else $error("estimation mode changed without write");
endmodule
bind servo_torque_mode_command_path servo_torque_props props_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .estInertiaRatio(estInertiaRatio), .estSpeedGain(estSpeedGain),
    .torqueCmd(torqueCmd), .loadInertiaRatio(loadInertiaRatio),
    .positionLoopGain(positionLoopGain), .speedLoopGain(speedLoopGain),
    .autoInertia(autoInertia), .autoSpeedGains(autoSpeedGains));
`default_nettype wire

/* verification/motion_controller_model.sv */
// motion controller model: select contacts and analog lines
// assumes bench requests at logic level, 1 = contact closed
`timescale 1ns/100ps
`default_nettype none
module motion_controller_model (
    input wire logic [1:0] torqueSel,
    input wire logic limitSel,
    input wire logic [2:0] speedSel,
    input wire logic signed [15:0] torqueMv,
    input wire logic signed [15:0] speedMv,
    output logic torqueSourceSelLowN,
    output logic torqueSourceSelHighN,
    output logic torqueLimitSelectN,
    output logic speedSelectBit0N,
    output logic speedSelectBit1N,
    output logic speedSelectBit2N,
    output logic signed [15:0] torqueAnalogMv,
    output logic signed [15:0] speedAnalogMv
);
    // a closed contact pulls its pin to common
    assign torqueSourceSelLowN = !torqueSel[0];
    assign torqueSourceSelHighN = !torqueSel[1];
    assign torqueLimitSelectN = !limitSel;
    assign speedSelectBit0N = !speedSel[0];
    assign speedSelectBit1N = !speedSel[1];
    assign speedSelectBit2N = !speedSel[2];
    // analog outputs stay inside the +-10 V span
    assign torqueAnalogMv = torqueMv > 16'sh2710 ? 16'sh2710 :
        torqueMv < -16'sh2710 ? -16'sh2710 : torqueMv;
    assign speedAnalogMv = speedMv > 16'sh2710 ? 16'sh2710 :
        speedMv < -16'sh2710 ? -16'sh2710 : speedMv;
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench of the torque command path over apb
// assumes the package, controller model and bound checker
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin samplesChecked++; \
    if ((got) !== (ex)) begin badCount++; \
    $display("unexpected %s exp %0d got %0d", nm, ex, got); end end
module tb
    import servo_torque_pkg::*;
;
    logic ref_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, rerr, limSel = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [1:0] tqSel = 2'h0;
    logic [2:0] spSel = 3'h0;
    logic signed [15:0] tqMv = 16'sh0, spMv = 16'sh0, tqA, spA, torqueCmd;
    logic signed [15:0] speedLimit;
    logic [15:0] estI = 16'h000b, estS = 16'h0016, estSi = 16'h0021;
    logic [15:0] inertia, posGain, spdGain, spdInteg;
    logic tlN, tsN, limN, s0N, s1N, s2N, autoI, autoS;
    int badCount = 0, samplesChecked = 0;
    int spd [7] = '{100, 500, 1000, 200, 300, 500, 800};
    int st [3] = '{20, -40, 60};
    initial forever #12.5 ref_clk = ~ref_clk;
    motion_controller_model ctl_u (.torqueSel(tqSel), .limitSel(limSel),
        .speedSel(spSel), .torqueMv(tqMv), .speedMv(spMv),
        .torqueSourceSelLowN(tlN), .torqueSourceSelHighN(tsN),
        .torqueLimitSelectN(limN), .speedSelectBit0N(s0N),
        .speedSelectBit1N(s1N), .speedSelectBit2N(s2N),
        .torqueAnalogMv(tqA), .speedAnalogMv(spA));
    servo_torque_mode_command_path #(.ENHANCED(1), .MS_CYCLES(8)) dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .torqueSourceSelLowN(tlN), .torqueSourceSelHighN(tsN),
        .torqueLimitSelectN(limN), .speedSelectBit0N(s0N),
        .speedSelectBit1N(s1N), .speedSelectBit2N(s2N),
        .torqueAnalogMv(tqA), .speedAnalogMv(spA),
        .estInertiaRatio(estI), .estSpeedGain(estS),
        .estSpeedIntegral(estSi), .torqueCmd(torqueCmd),
        .speedLimit(speedLimit), .loadInertiaRatio(inertia),
        .positionLoopGain(posGain), .speedLoopGain(spdGain),
        .speedIntegralGain(spdInteg), .autoInertia(autoI),
        .autoSpeedGains(autoS));
    task automatic giveVerdict();
        $display("checked %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one apb transfer; answer and read data taken at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            badCount++;
            giveVerdict();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), ex, rdat)
        `CHK("slverr", 1'b0, rerr)
    endtask
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic tq(input int s, input logic l, input int mv);
        @(posedge ref_clk);
        tqSel <= 2'(s);
        limSel <= l;
        tqMv <= 16'(mv);
        settle();
    endtask
    task automatic sp(input int s, input int mv);
        @(posedge ref_clk);
        spSel <= 3'(s);
        spMv <= 16'(mv);
        settle();
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        `CHK("inertia", 16'h0046, inertia)
        `CHK("posgain", 16'h002d, posGain)
        rdc(ADDR_CTRL, 32'h1);
        rdc(ADDR_STATUS, 32'h200);
        rdc(ADDR_TQ_SCALE, 32'h64);
        rdc(ADDR_TQ_OFFSET, 32'h0);
        rdc(ADDR_TQ_FILTER, 32'h0);
        rdc(ADDR_TQ_LIM1, 32'h64);
        rdc(ADDR_TQ_LIM2, 32'h64);
        rdc(ADDR_MAX_SPEED, 32'hbb8);
        for (int i = 0; i < 7; i++)
            rdc(ADDR_SPD_STORED0 + 8'(4 * i), 32'(spd[i]));
        wr(ADDR_STATUS, 32'hffff);
        rdc(ADDR_STATUS, 32'h200);
        apb(1'b0, 8'h60, 32'h0);
        `CHK("unmapped", 1'b1, rerr)
        apb(1'b1, 8'h02, 32'h5);
        `CHK("unaligned", 1'b1, rerr)
        tq(0, 1'b0, 5000);
        `CHK("tq", 500, torqueCmd)
        tq(0, 1'b0, 10000);
        `CHK("tq", 1000, torqueCmd)
        wr(ADDR_TQ_SCALE, 32'hbb8);
        rdc(ADDR_TQ_SCALE, 32'h7d0);
        wr(ADDR_TQ_SCALE, 32'hc8);
        tq(0, 1'b0, 4000);
        `CHK("tq", 800, torqueCmd)
        wr(ADDR_TQ_OFFSET, 32'h1f4);
        tq(0, 1'b0, 1000);
        `CHK("tq", 300, torqueCmd)
        wr(ADDR_TQ_OFFSET, 32'hffffdcd8);
        rdc(ADDR_TQ_OFFSET, 32'hffffe0c0);
        wr(ADDR_TQ_OFFSET, 32'h0);
        wr(ADDR_TQ_SCALE, 32'h7d0);
        tq(0, 1'b0, -1000);
        `CHK("tq", -1000, torqueCmd)
        wr(ADDR_TQ_SCALE, 32'h64);
        wr(ADDR_TQ_LIM1, 32'h50);
        wr(ADDR_TQ_LIM2, 32'h1e);
        tq(0, 1'b1, 10000);
        `CHK("tq", 800, torqueCmd)
        wr(ADDR_CTRL, 32'h3);
        settle();
        `CHK("tq", 300, torqueCmd)
        tq(0, 1'b0, 10000);
        `CHK("tq", 800, torqueCmd)
        wr(ADDR_TQ_LIM2, 32'h5a);
        tq(0, 1'b1, 10000);
        `CHK("tq", 800, torqueCmd)
        wr(ADDR_TQ_LIM1, 32'h64);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_TQ_STORED0 + 8'(4 * i), 32'(st[i]));
            tq(i + 1, 1'b0, 0);
            `CHK("stored", st[i] * 10, torqueCmd)
        end
        tq(0, 1'b0, 0);
        wr(ADDR_TQ_FILTER, 32'h1770);
        rdc(ADDR_TQ_FILTER, 32'h1388);
        wr(ADDR_TQ_FILTER, 32'h4);
        repeat (40) @(posedge ref_clk);
        tq(0, 1'b0, 8000);
        `CHK("filt", 1'b1, torqueCmd < 16'sh0320)
        repeat (400) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("filt", 1'b1, torqueCmd > 16'sh02bc)
        wr(ADDR_CTRL, 32'h2);
        tq(0, 1'b0, 4000);
        `CHK("tq", 400, torqueCmd)
        tq(0, 1'b0, 8000);
        wr(ADDR_TQ_FILTER, 32'h0);
        settle();
        `CHK("tq", 800, torqueCmd)
        sp(0, 5000);
        `CHK("spd", 1500, speedLimit)
        sp(0, -10000);
        `CHK("spd", -3000, speedLimit)
        for (int s = 1; s < 4; s++) begin
            sp(s, 0);
            `CHK("spd", spd[s - 1], speedLimit)
        end
        sp(5, 0);
        `CHK("spd", 100, speedLimit)
        wr(ADDR_CTRL, 32'h7);
        for (int s = 1; s < 8; s++) begin
            sp(s, 0);
            `CHK("spd", spd[s - 1], speedLimit)
        end
        wr(ADDR_POS_GAIN, 32'h64);
        wr(ADDR_INERTIA, 32'hc8);
        wr(ADDR_CTRL, 32'h17);
        settle();
        `CHK("autoI", 1'b1, autoI)
        `CHK("autoS", 1'b1, autoS)
        `CHK("inertia", estI, inertia)
        `CHK("integ", estSi, spdInteg)
        `CHK("posgain", 16'h0064, posGain)
        wr(ADDR_CTRL, 32'h27);
        settle();
        `CHK("autoI", 1'b0, autoI)
        `CHK("inertia", 16'h00c8, inertia)
        `CHK("spdgain", estS, spdGain)
        `CHK("posgain", 16'h0064, posGain)
        wr(ADDR_CTRL, 32'h37);
        rdc(ADDR_CTRL, 32'h7);
        giveVerdict();
    end
endmodule
`default_nettype wire
